//--- verilog/fhip_cfg.svh
/*
  Floppy host interface: register offsets, bit positions, a kept-status mask and limits.
  Assumes it is included by bare name from the package and the end modules.
*/
`ifndef FHIP_CFG_SVH
`define FHIP_CFG_SVH

`define FHIP_REG_CMD      1'b0
`define FHIP_REG_DATA     1'b1

`define FHIP_CMD_GO       0
`define FHIP_CMD_FUNC_LO  1
`define FHIP_CMD_FUNC_HI  3
`define FHIP_CMD_UNIT     4
`define FHIP_CMD_DONE     5
`define FHIP_CMD_IE       6
`define FHIP_CMD_TR       7
`define FHIP_CMD_DENS     8
`define FHIP_CMD_SYSID    11
`define FHIP_CMD_INIT     14
`define FHIP_CMD_ERR      15

`define FHIP_ES_CRC       0
`define FHIP_ES_INITDN    2
`define FHIP_ES_PWR       3
`define FHIP_ES_DENERR    4
`define FHIP_ES_DRVDEN    5
`define FHIP_ES_DELDAT    6
`define FHIP_ES_DRVRDY    7
`define FHIP_ES_UNIT      8
`define FHIP_ES_WCOVF     10
`define FHIP_ES_NXM       11
`define FHIP_ES_KEEP      16'h00A0

`define FHIP_WC_DOUBLE    8'h80
`define FHIP_WC_SINGLE    8'h40
`define FHIP_BUF_WORDS    128
`define FHIP_ADDR_STEP    16'h0002
`define FHIP_HOST_WORDS   256

`define FHIP_SW_PTR       2'h2
`define FHIP_SW_MEM       2'h3

`endif

//--- verilog/fhip_pkg.sv
/*
  Floppy host interface types: function codes, controller states, state records.
  Assumes fhip_cfg.svh is on the include path.
*/
`include "fhip_cfg.svh"

package fhip_pkg;

    typedef enum logic [2:0] {
        FN_FILL   = 3'h0,
        FN_EMPTY  = 3'h1,
        FN_WRITE  = 3'h2,
        FN_READ   = 3'h3,
        FN_DENS   = 3'h4,
        FN_STATUS = 3'h5,
        FN_WRDEL  = 3'h6,
        FN_ERRCD  = 3'h7
    } fhip_func_e;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_INIT    = 4'h1,
        ST_WAIT_WC = 4'h2,
        ST_WAIT_BA = 4'h3,
        ST_FILL    = 4'h4,
        ST_ZERO    = 4'h5,
        ST_EMPTY   = 4'h6,
        ST_WAIT_SA = 4'h7,
        ST_WAIT_TA = 4'h8,
        ST_SEEK    = 4'h9,
        ST_STAT    = 4'hA
    } fhip_state_e;

    typedef struct packed {
        fhip_state_e state;
        fhip_func_e  func;
        logic        unit;
        logic        dens;
        logic        ie;
        logic        err;
        logic        done;
        logic        tr;
        logic        pwr_q;
        logic [15:0] es;
        logic [15:0] data;
        logic [15:0] ptr;
        logic [7:0]  wc;
        logic [7:0]  cnt;
        logic [7:0]  track;
        logic [7:0]  sector;
        logic [15:0] rdata;
    } fhip_dev_s;

    typedef struct packed {
        logic        ack;
        logic        nxm;
        logic        sel;
        logic [15:0] dma_rdata;
        logic [15:0] mptr;
        logic [15:0] mq;
    } fhip_host_s;

endpackage : fhip_pkg

//--- verilog/fhip_if.sv
/*
  Floppy host interface link: register access and DMA between host and device.
  Assumes both ends share clk_i; the testbench instantiates and joins them.
*/
`timescale 1ns/1ps

interface fhip_if;
    logic        reg_sel;
    logic [15:0] reg_wdata;
    logic        reg_we;
    logic        reg_re;
    logic [15:0] reg_rdata;
    logic        dma_req;
    logic        dma_write;
    logic [15:0] dma_addr;
    logic [15:0] dma_wdata;
    logic        dma_ack;
    logic        dma_nxm;
    logic [15:0] dma_rdata;

    modport dev (
        input  reg_sel, reg_wdata, reg_we, reg_re, dma_ack, dma_nxm, dma_rdata,
        output reg_rdata, dma_req, dma_write, dma_addr, dma_wdata
    );
    modport host (
        output reg_sel, reg_wdata, reg_we, reg_re, dma_ack, dma_nxm, dma_rdata,
        input  reg_rdata, dma_req, dma_write, dma_addr, dma_wdata
    );
endinterface : fhip_if

//--- verilog/fhip_sync.sv
/*
  Two-stage level synchroniser.
  Assumes the input is asynchronous to clk_i; only the second stage is read.
*/
`timescale 1ns/1ps

module fhip_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule : fhip_sync

//--- verilog/fhip_host.sv
/*
  Host end: forwards software register accesses to the device and serves DMA
  from a local word memory. Assumes software follows the handoff protocol.
*/
`timescale 1ns/1ps
`include "fhip_cfg.svh"

module fhip_host
    import fhip_pkg::*;
#(
    parameter int MEM_WORDS = `FHIP_HOST_WORDS
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [1:0]  sw_addr_i,
    input  wire logic [15:0] sw_wdata_i,
    input  wire logic        sw_we_i,
    input  wire logic        sw_re_i,
    output logic [15:0]      sw_rdata_o,
    fhip_if.host             bus
);
    localparam int          AW      = $clog2(MEM_WORDS);
    localparam logic [15:0] MEM_LIM = 16'(MEM_WORDS);

    if (MEM_WORDS < 2 || MEM_WORDS > 32768 || (1 << AW) != MEM_WORDS) begin : g_chk
        $error("fhip_host: MEM_WORDS must be a power of two from 2 to 32768");
    end

    logic [15:0] mem [MEM_WORDS];
    fhip_host_s  r_r;
    fhip_host_s  r_nxt;
    logic        mem_we;
    logic [AW-1:0] mem_wa;
    logic [15:0] mem_wd;
    logic        sw_mem;
    logic [AW-1:0] dma_idx;
    logic [AW-1:0] sw_idx;

    assign bus.reg_sel   = sw_addr_i[0];
    assign bus.reg_wdata = sw_wdata_i;
    assign bus.reg_we    = sw_we_i & ~sw_addr_i[1];
    assign bus.reg_re    = sw_re_i & ~sw_addr_i[1];
    assign bus.dma_ack   = r_r.ack;
    assign bus.dma_nxm   = r_r.nxm;
    assign bus.dma_rdata = r_r.dma_rdata;
    assign sw_rdata_o    = r_r.sel ? bus.reg_rdata : r_r.mq;
    assign sw_mem        = (sw_we_i | sw_re_i) & (sw_addr_i == `FHIP_SW_MEM);
    assign dma_idx       = bus.dma_addr[AW:1];
    assign sw_idx        = r_r.mptr[AW:1];

    always_comb begin
        r_nxt  = r_r;
        mem_we = 1'b0;
        mem_wa = sw_idx;
        mem_wd = sw_wdata_i;
        r_nxt.ack = 1'b0;
        r_nxt.nxm = 1'b0;
        // Memory port busy with software: DMA simply waits a cycle
        if (bus.dma_req && !r_r.ack && !sw_mem) begin
            r_nxt.ack = 1'b1;
            r_nxt.nxm = {1'b0, bus.dma_addr[15:1]} >= MEM_LIM; // R16
            if (bus.dma_write) begin
                mem_we = ~r_nxt.nxm; // R20
                mem_wa = dma_idx;
                mem_wd = bus.dma_wdata;
            end else begin
                r_nxt.dma_rdata = mem[dma_idx]; // R18
            end
        end
        if (sw_re_i) begin
            r_nxt.sel = ~sw_addr_i[1];
        end
        if (sw_addr_i == `FHIP_SW_PTR) begin
            if (sw_we_i) begin
                r_nxt.mptr = sw_wdata_i;
            end
            if (sw_re_i) begin
                r_nxt.mq = r_r.mptr;
            end
        end
        if (sw_mem) begin
            mem_we     = sw_we_i;
            r_nxt.mptr = r_r.mptr + `FHIP_ADDR_STEP;
            if (sw_re_i) begin
                r_nxt.mq = mem[sw_idx];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
endmodule : fhip_host

//--- verilog/fhip_dev.sv
/*
  Device end: command word, shared data port, sector buffer, DMA engine and
  drive sequencing. Assumes the drive side answers each seek with drv_done_i.
*/
// Design decisions made here: strobed register access and the placing of the registers.
// How it works
// R1: Data port free when idle, gated by handoff
// R2: Track uses low byte only, protocol only
// R3: Sector accepted only inside function handshake
// R4: Word count limit 128 or 64, overflow
// R5: DMA pointer steps after each memory transaction
// R6: Status word lands in data port at end
// R7: Checksum error sets bit 0, error, done
// R8: Initialize completion sets status bit 2
// R9: Subsystem power loss sets status bit 3
// R10: Density mismatch sets bit 4, aborts
// R11: Bit 5 shows diskette density after seek
// R12: Deleted mark sets bit 6, data kept
// R13: Bit 7 drive ready, after status/init
// R14: Bit 8 shows selected drive
// R15: Count beyond sector sets bit 10, aborts
// R16: Missing memory during DMA sets bit 11
// R17: Command bits 1-3 pick eight functions
// R18: Fill: count, address, DMA read, zero-fill
// R19: Fill ignores drive select, reads ignored
// R20: Empty: same handshake, DMA write out
// R21: Write sector: sector then track handoff
// R22: Write density mismatch: bit 4, error, done
// R23: Go bit starts function only when idle
`timescale 1ns/1ps
`include "fhip_cfg.svh"
module fhip_dev
    import fhip_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    fhip_if.dev              bus,
    input  wire logic        power_loss_i,
    input  wire logic [1:0]  drv_ready_i,
    input  wire logic        drv_done_i,
    input  wire logic        drv_density_i,
    input  wire logic        drv_crc_err_i,
    input  wire logic        drv_deleted_i,
    input  wire logic        drv_buf_we_i,
    input  wire logic [6:0]  drv_buf_addr_i,
    input  wire logic [15:0] drv_buf_wdata_i,
    output logic [15:0]      drv_buf_rdata_o,
    output logic             drv_start_o,
    output logic [2:0]       drv_func_o,
    output logic             drv_unit_o,
    output logic             drv_dens_o,
    output logic [7:0]       drv_track_o,
    output logic [7:0]       drv_sector_o
);
    logic [15:0] sbuf [`FHIP_BUF_WORDS];
    fhip_dev_s   r_r;
    fhip_dev_s   r_nxt;
    logic        pwr_s;
    logic        buf_we;
    logic [6:0]  buf_wa;
    logic [15:0] buf_wd;
    logic [15:0] memq_r;
    logic [7:0]  limit;
    logic [15:0] cmd_word;
    logic        busy;
    logic        cmd_wr;
    logic        data_wr;
    logic        take;
    logic        xfer;
    fhip_sync u_pwr_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (power_loss_i),
        .q_o     (pwr_s)
    );
    // Ends a function with the status word in the data port
    function automatic fhip_dev_s finish_f(input fhip_dev_s s, input logic e);
        s.err   = s.err | e;
        s.done  = 1'b1;
        s.tr    = 1'b0;
        s.state = ST_IDLE;
        s.data  = s.es;
        s.data[`FHIP_ES_UNIT] = s.unit; // R6 R14
        return s;
    endfunction : finish_f
    assign busy    = (r_r.state != ST_IDLE);
    assign cmd_wr  = bus.reg_we & (bus.reg_sel == `FHIP_REG_CMD);
    assign data_wr = bus.reg_we & (bus.reg_sel == `FHIP_REG_DATA);
    assign take    = data_wr & r_r.tr; // R1
    assign limit   = r_r.dens ? `FHIP_WC_DOUBLE : `FHIP_WC_SINGLE; // R4 R19
    assign xfer    = (r_r.cnt != r_r.wc);
    assign bus.reg_rdata = r_r.rdata;
    assign bus.dma_req   = ((r_r.state == ST_FILL) | (r_r.state == ST_EMPTY)) & xfer;
    assign bus.dma_write = (r_r.state == ST_EMPTY);
    assign bus.dma_addr  = r_r.ptr;
    assign bus.dma_wdata = memq_r;
    assign drv_start_o   = (r_r.state == ST_SEEK);
    assign drv_func_o    = r_r.func;
    assign drv_unit_o    = r_r.unit;
    assign drv_dens_o    = r_r.dens;
    assign drv_track_o   = r_r.track;
    assign drv_sector_o  = r_r.sector;
    always_comb begin
        cmd_word = 16'h0000;
        cmd_word[`FHIP_CMD_ERR]   = r_r.err;
        cmd_word[`FHIP_CMD_SYSID] = 1'b1;
        cmd_word[`FHIP_CMD_DENS]  = r_r.done & r_r.dens;
        cmd_word[`FHIP_CMD_TR]    = r_r.tr;
        cmd_word[`FHIP_CMD_IE]    = r_r.ie;
        cmd_word[`FHIP_CMD_DONE]  = r_r.done;
        cmd_word[`FHIP_CMD_UNIT]  = r_r.done & r_r.unit;
    end
    always_comb begin
        r_nxt     = r_r;
        buf_we    = 1'b0;
        buf_wa    = r_r.cnt[6:0];
        buf_wd    = bus.dma_rdata;
        r_nxt.pwr_q = pwr_s;
        if (bus.reg_re) begin
            r_nxt.rdata = (bus.reg_sel == `FHIP_REG_CMD) ? cmd_word : r_r.data; // R1 R19
        end
        unique case (r_r.state)
            ST_IDLE: begin
                if (data_wr) begin
                    r_nxt.data = bus.reg_wdata; // R1
                end
            end
            ST_INIT: begin
                r_nxt.es = 16'h0000;
                r_nxt.es[`FHIP_ES_INITDN] = 1'b1; // R8
                r_nxt.es[`FHIP_ES_DRVRDY] = drv_ready_i[r_r.unit]; // R13
                r_nxt.es[`FHIP_ES_DRVDEN] = drv_density_i;
                r_nxt = finish_f(r_nxt, 1'b0);
            end
            ST_STAT: begin
                r_nxt.es[`FHIP_ES_DRVRDY] = drv_ready_i[r_r.unit]; // R13
                r_nxt = finish_f(r_nxt, 1'b0);
            end
            ST_WAIT_WC: begin
                r_nxt.tr = ~take;
                if (take) begin
                    r_nxt.wc = bus.reg_wdata[7:0];
                    r_nxt.state = ST_WAIT_BA;
                    if (bus.reg_wdata > {8'h00, limit}) begin
                        r_nxt.es[`FHIP_ES_WCOVF] = 1'b1; // R4 R15
                        r_nxt = finish_f(r_nxt, 1'b1);
                    end
                end
            end
            ST_WAIT_BA: begin
                r_nxt.tr = ~take;
                if (take) begin
                    r_nxt.ptr   = bus.reg_wdata; // R5
                    r_nxt.cnt   = 8'h00;
                    r_nxt.state = (r_r.func == FN_FILL) ? ST_FILL : ST_EMPTY; // R18 R20
                end
            end
            ST_FILL, ST_EMPTY: begin
                if (!xfer) begin
                    if (r_r.state == ST_FILL) begin
                        r_nxt.state = ST_ZERO;
                    end else begin
                        r_nxt = finish_f(r_nxt, 1'b0); // R20
                    end
                end else if (bus.dma_ack) begin
                    if (bus.dma_nxm) begin
                        r_nxt.es[`FHIP_ES_NXM] = 1'b1; // R16
                        r_nxt = finish_f(r_nxt, 1'b1);
                    end else begin
                        buf_we    = (r_r.state == ST_FILL); // R18
                        r_nxt.cnt = r_r.cnt + 8'h01;
                        r_nxt.ptr = r_r.ptr + `FHIP_ADDR_STEP; // R5
                    end
                end
            end
            ST_ZERO: begin
                if (r_r.cnt == limit) begin
                    r_nxt = finish_f(r_nxt, 1'b0); // R18
                end else begin
                    buf_we    = 1'b1;
                    buf_wd    = 16'h0000;
                    r_nxt.cnt = r_r.cnt + 8'h01;
                end
            end
            ST_WAIT_SA: begin
                r_nxt.tr = ~take;
                if (take) begin
                    r_nxt.sector = bus.reg_wdata[7:0]; // R3 R21
                    r_nxt.state  = ST_WAIT_TA;
                end
            end
            ST_WAIT_TA: begin
                r_nxt.tr = ~take; // R21
                if (take) begin
                    r_nxt.track = bus.reg_wdata[7:0]; // R2
                    r_nxt.state = ST_SEEK;
                end
            end
            ST_SEEK: begin
                if (drv_done_i) begin
                    r_nxt.es[`FHIP_ES_DRVDEN] = drv_density_i; // R11
                    if (drv_density_i != r_r.dens) begin
                        r_nxt.es[`FHIP_ES_DENERR] = 1'b1; // R10 R22
                        r_nxt = finish_f(r_nxt, 1'b1);
                    end else begin
                        r_nxt.es[`FHIP_ES_DELDAT] = (r_r.func == FN_READ) & drv_deleted_i; // R12
                        r_nxt.es[`FHIP_ES_CRC]    = (r_r.func == FN_READ) & drv_crc_err_i; // R7
                        r_nxt = finish_f(r_nxt, r_nxt.es[`FHIP_ES_CRC]);
                    end
                end
            end
            default: begin
                r_nxt.state = ST_IDLE;
            end
        endcase
        // Power events win over any function in progress
        if (pwr_s && !r_r.pwr_q) begin
            r_nxt.es[`FHIP_ES_PWR] = 1'b1; // R9
            r_nxt = finish_f(r_nxt, 1'b1);
        end else if (!pwr_s && r_r.pwr_q) begin
            r_nxt.done  = 1'b0;
            r_nxt.state = ST_INIT; // R8
        end else if (cmd_wr && bus.reg_wdata[`FHIP_CMD_INIT]) begin
            r_nxt.done  = 1'b0;
            r_nxt.err   = 1'b0;
            r_nxt.ie    = 1'b0;
            r_nxt.tr    = 1'b0;
            r_nxt.state = ST_INIT; // R8
        end else if (cmd_wr && !busy) begin
            r_nxt.unit = bus.reg_wdata[`FHIP_CMD_UNIT];
            r_nxt.dens = bus.reg_wdata[`FHIP_CMD_DENS];
            r_nxt.ie   = bus.reg_wdata[`FHIP_CMD_IE];
            if (bus.reg_wdata[`FHIP_CMD_GO]) begin // R23
                r_nxt.func = fhip_func_e'(bus.reg_wdata[`FHIP_CMD_FUNC_HI:`FHIP_CMD_FUNC_LO]);
                r_nxt.done = 1'b0;
                r_nxt.err  = 1'b0;
                r_nxt.tr   = 1'b0; // R21
                r_nxt.es   = r_r.es & `FHIP_ES_KEEP;
                unique case (r_nxt.func) // R17
                    FN_FILL, FN_EMPTY: begin
                        r_nxt.unit  = r_r.unit; // R19
                        r_nxt.state = ST_WAIT_WC;
                    end
                    FN_WRITE, FN_READ, FN_WRDEL: begin
                        r_nxt.state = ST_WAIT_SA;
                    end
                    FN_DENS, FN_STATUS, FN_ERRCD: begin
                        r_nxt.state = ST_STAT;
                    end
                endcase
            end
        end
    end
    // Drive writes only land while the device sits in seek
    always_ff @(posedge clk_i) begin
        if (buf_we) begin
            sbuf[buf_wa] <= buf_wd;
        end else if (drv_buf_we_i && r_r.state == ST_SEEK) begin
            sbuf[drv_buf_addr_i] <= drv_buf_wdata_i;
        end
        memq_r          <= sbuf[r_nxt.cnt[6:0]];
        drv_buf_rdata_o <= sbuf[drv_buf_addr_i];
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_r       <= '0;
            r_r.state <= ST_INIT;
        end else begin
            r_r <= r_nxt;
        end
    end
endmodule : fhip_dev

//--- tb/fhip_asserts.sv
/*
  Checker for the host-device link: DMA handshake, pointer steps, register reads.
  Assumes one clock; the testbench instantiates it beside the link.
*/
`timescale 1ns/1ps

module fhip_asserts #(
    parameter int MEM_WORDS = 256
) (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_we,
    input wire logic        reg_re,
    input wire logic [15:0] reg_rdata,
    input wire logic        dma_req,
    input wire logic        dma_write,
    input wire logic [15:0] dma_addr,
    input wire logic [15:0] dma_wdata,
    input wire logic        dma_ack,
    input wire logic        dma_nxm,
    input wire logic [15:0] dma_rdata
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Acks since last register write; saturates so it cannot wrap
    logic [7:0] acks_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acks_r <= 8'h00;
        end else if (reg_we) begin
            acks_r <= 8'h00;
        end else if (dma_ack && acks_r != 8'hFF) begin
            acks_r <= acks_r + 8'h01;
        end
    end

    sequence s_pending;
        dma_req && !dma_ack;
    endsequence

    sequence s_answered;
        ##[1:2] dma_ack;
    endsequence

    a_ack_bound: assert property (s_pending |-> s_answered)
        else $error("dma request not answered");
    a_req_hold: assert property (s_pending |=> dma_req && $stable(dma_addr)
        && $stable(dma_write) && $stable(dma_wdata))
        else $error("dma request changed before ack");
    a_ptr_step: assert property (dma_ack && !dma_nxm |=>
        dma_addr == $past(dma_addr) + 16'h0002)
        else $error("pointer did not step by one word");
    a_ack_gap: assert property (dma_ack |=> !dma_ack)
        else $error("ack longer than one cycle");
    a_nxm_ack: assert property (dma_nxm |-> dma_ack)
        else $error("nxm without ack");
    a_nxm_range: assert property (dma_ack |-> dma_nxm == (dma_addr[15:1] >= MEM_WORDS))
        else $error("nxm disagrees with address");
    a_rdata_hold: assert property (!reg_re |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_tr_done_excl: assert property (reg_re && !reg_sel |=> !(reg_rdata[5] && reg_rdata[7]))
        else $error("handoff and done both set");
    a_wc_limit: assert property (acks_r <= 8'h80)
        else $error("more words moved than a sector holds");
endmodule : fhip_asserts

//--- tb/tb.sv
/*
  Testbench: joins host and device ends, drives software accesses and drive events.
  Assumes a 25 MHz clock and a host memory of 256 words.
*/
`timescale 1ns/1ps

module tb
    import fhip_pkg::*;
();
    logic        clk_i     = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [1:0]  sw_addr   = 2'h0;
    logic [15:0] sw_wdata  = 16'h0000;
    logic        sw_we     = 1'b0;
    logic        sw_re     = 1'b0;
    logic        pwr_lost  = 1'b0;
    logic [1:0]  drv_ready = 2'h1;
    logic        drv_done  = 1'b0;
    logic        drv_dn    = 1'b1;
    logic        drv_crc   = 1'b0;
    logic        drv_del   = 1'b0;
    logic        buf_we    = 1'b0;
    logic [6:0]  buf_addr  = 7'h03;
    logic [15:0] buf_wdata = 16'hBEEF;
    logic [15:0] sw_rdata, buf_rdata, d;
    logic        drv_start, drv_unit, drv_dens;
    logic [2:0]  drv_func;
    logic [7:0]  drv_track, drv_sector;
    logic [15:0] wcs [3]   = '{16'h0040, 16'h0041, 16'h0081};
    fhip_func_e  fns [3]   = '{FN_DENS, FN_STATUS, FN_ERRCD};
    int          bad_count = 0;
    int          cmp_count = 0;

    always #20 clk_i = ~clk_i;

    fhip_if bus_if ();
    fhip_host #(.MEM_WORDS(256)) fhip_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_we_i(sw_we), .sw_re_i(sw_re),
        .sw_rdata_o(sw_rdata), .bus(bus_if));
    fhip_dev fhip_dev_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
        .power_loss_i(pwr_lost), .drv_ready_i(drv_ready), .drv_done_i(drv_done),
        .drv_density_i(drv_dn), .drv_crc_err_i(drv_crc), .drv_deleted_i(drv_del),
        .drv_buf_we_i(buf_we), .drv_buf_addr_i(buf_addr), .drv_buf_wdata_i(buf_wdata),
        .drv_buf_rdata_o(buf_rdata), .drv_start_o(drv_start), .drv_func_o(drv_func),
        .drv_unit_o(drv_unit), .drv_dens_o(drv_dens), .drv_track_o(drv_track),
        .drv_sector_o(drv_sector));
    fhip_asserts #(.MEM_WORDS(256)) fhip_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .reg_sel(bus_if.reg_sel), .reg_wdata(bus_if.reg_wdata), .reg_we(bus_if.reg_we),
        .reg_re(bus_if.reg_re), .reg_rdata(bus_if.reg_rdata), .dma_req(bus_if.dma_req),
        .dma_write(bus_if.dma_write), .dma_addr(bus_if.dma_addr),
        .dma_wdata(bus_if.dma_wdata), .dma_ack(bus_if.dma_ack),
        .dma_nxm(bus_if.dma_nxm), .dma_rdata(bus_if.dma_rdata));

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    task automatic fail(input string msg);
        bad_count++;
        $display("ERROR %0t: %s", $time, msg);
        results();
    endtask : fail

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Strobe drops one edge later, so back-to-back calls never collide
    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge clk_i);
        sw_addr  <= a;
        sw_wdata <= v;
        sw_we    <= 1'b1;
        @(posedge clk_i);
        sw_we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [15:0] v);
        @(posedge clk_i);
        sw_addr <= a;
        sw_re   <= 1'b1;
        @(posedge clk_i);
        sw_re <= 1'b0;
        #1 v = sw_rdata;
    endtask : rd

    task automatic wait_bit(input logic [1:0] a, input int b);
        logic [15:0] v;
        for (int n = 0; n < 400; n++) begin
            rd(a, v);
            if (v[b] === 1'b1) return;
        end
        fail("wait timed out");
    endtask : wait_bit

    task automatic go(input logic [2:0] f, input logic u, input logic dn);
        wr(2'h0, {7'h00, dn, 3'h0, u, f, 1'b1});
    endtask : go

    task automatic fin(input logic [15:0] m, input logic [15:0] e, input logic er);
        wait_bit(2'h0, 5);
        rd(2'h1, d);
        chk(d & m, e);
        rd(2'h0, d);
        chk({15'h0, d[15]}, {15'h0, er});
        $display("test step done");
    endtask : fin

    // Unit select set on purpose: buffer functions must ignore it
    task automatic xfer(input logic [2:0] f, input logic dn, input logic [15:0] wc,
                        input logic [15:0] ba, input logic ovf);
        go(f, 1'b1, dn);
        wait_bit(2'h0, 7);
        wr(2'h1, wc);
        if (!ovf) begin
            wait_bit(2'h0, 7);
            wr(2'h1, ba);
        end
    endtask : xfer

    task automatic sector(input logic [2:0] f, input logic u, input logic dn,
                          input logic [15:0] sa, input logic [15:0] ta);
        go(f, u, dn);
        wait_bit(2'h0, 7);
        go(FN_FILL, 1'b0, 1'b1);
        wr(2'h1, sa);
        wait_bit(2'h0, 7);
        wr(2'h1, ta);
    endtask : sector

    task automatic seek(input logic c, input logic dl);
        for (int n = 0; n < 100 && drv_start !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        if (drv_start !== 1'b1) fail("seek not started");
        @(posedge clk_i);
        buf_we <= 1'b1;
        @(posedge clk_i);
        buf_we   <= 1'b0;
        drv_done <= 1'b1;
        drv_crc  <= c;
        drv_del  <= dl;
        @(posedge clk_i);
        drv_done <= 1'b0;
        drv_crc  <= 1'b0;
        drv_del  <= 1'b0;
    endtask : seek

    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wait_bit(2'h1, 2);
        rd(2'h1, d);
        chk(d & 16'h00A4, 16'h00A4);
        rd(2'h0, d);
        chk(d & 16'h0820, 16'h0820);
        wr(2'h1, 16'h1234);
        rd(2'h1, d);
        chk(d, 16'h1234);
        $display("test init done");
        wr(2'h2, 16'h0010);
        for (int i = 0; i < 4; i++) wr(2'h3, 16'hA000 + 16'(i));
        xfer(FN_FILL, 1'b0, 16'h0004, 16'h0010, 1'b0);
        fin(16'h0D11, 16'h0000, 1'b0);
        xfer(FN_EMPTY, 1'b1, 16'h0006, 16'h0040, 1'b0);
        fin(16'h0D11, 16'h0000, 1'b0);
        wr(2'h2, 16'h0040);
        for (int i = 0; i < 6; i++) begin
            rd(2'h3, d);
            chk(d, (i < 4) ? 16'hA000 + 16'(i) : 16'h0000);
        end
        for (int i = 0; i < 3; i++) begin
            xfer(FN_FILL, i[1], wcs[i], 16'h0000, i > 0);
            fin(16'h0400, (i > 0) ? 16'h0400 : 16'h0000, i > 0);
        end
        xfer(FN_EMPTY, 1'b1, 16'h0001, 16'h0200, 1'b0);
        fin(16'h0800, 16'h0800, 1'b1);
        @(posedge clk_i) drv_dn <= 1'b0;
        sector(FN_WRITE, 1'b1, 1'b1, 16'h0005, 16'hFF0A);
        seek(1'b0, 1'b0);
        chk({8'h00, drv_track}, 16'h000A);
        chk({8'h00, drv_sector}, 16'h0005);
        chk({11'h000, drv_dens, drv_unit, drv_func}, 16'h001A);
        fin(16'h0130, 16'h0110, 1'b1);
        @(posedge clk_i) drv_dn <= 1'b1;
        sector(FN_READ, 1'b0, 1'b1, 16'h0001, 16'h0000);
        seek(1'b1, 1'b1);
        fin(16'h0071, 16'h0061, 1'b1);
        chk(buf_rdata, 16'hBEEF);
        for (int f = 0; f < 3; f++) begin
            go(fns[f], f[0], 1'b1);
            fin(16'h0180, {7'h00, f[0], ~f[0], 7'h00}, 1'b0);
        end
        @(posedge clk_i);
        pwr_lost <= 1'b1;
        wait_bit(2'h1, 3);
        rd(2'h0, d);
        chk(d & 16'h8020, 16'h8020);
        @(posedge clk_i);
        pwr_lost <= 1'b0;
        wait_bit(2'h1, 2);
        $display("test power done");
        results();
    end
endmodule : tb
